// ---- hdl/strap_regs.svh ----
// strap layout, register offsets and reset values for the strap capture block
`ifndef STRAP_REGS_SVH
`define STRAP_REGS_SVH
`define STRAP_W            16
`define STRAP_DEBOUNCE     0
`define STRAP_MGMT_MODE    3
`define STRAP_ADDR_LO      4
`define STRAP_ADDR_HI      6
`define STRAP_EEPROM_ABS   7
`define STRAP_MOD_DETECT   9
`define STRAP_PWR_SAVE     11
`define STRAP_TO_RESET     12
`define STAT_INIT_START    0
`define STAT_MBIST_BUSY    1
`define STAT_INIT_DONE     2
`define STAT_CSUM_GOOD     3
`define STAT_W             4
`define FAST_W             8
`define UPL_W              2
`define ADDR_W             4
`define DATA_W             32
`define OFF_FAST_READBACK  4'h0
`define OFF_UPL_READBACK   4'h1
`define OFF_STRAP_RAW      4'h2
`define OFF_CONFIG         4'h3
`define STRAP_RST          16'h0000
`define DATA_ZERO          32'h0000_0000
`endif

// ---- hdl/strap_pkg.sv ----
// types shared by the strap capture block
package strap_pkg;
  typedef struct packed {
    logic       debounce_en;
    logic       lightly_managed;
    logic [2:0] dev_addr;
    logic       eeprom_present;
    logic       module_detect_en;
    logic       mac_power_save;
    logic       timeout_reset_en;
  } strap_cfg_t;

  typedef struct packed {
    logic       ckchk_good;
    logic       init_done;
    logic       mbist_busy;
    logic       init_start;
  } init_status_t;

  typedef enum logic [2:0] {
    CAP_RESET  = 3'h1,
    CAP_SETTLE = 3'h2,
    CAP_RUN    = 3'h4
  } cap_state_t;
endpackage

// ---- hdl/strap_sync.sv ----
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module strap_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,  // system clock
  input  wire logic         rst_b,    // sync reset, active low
  input  wire logic [W-1:0] pin_in,   // asynchronous pin levels
  output logic      [W-1:0] pin_sync  // levels in clk_sys domain
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule

// ---- hdl/strap_serial_drv.sv ----
// serial data out driver: open drain or push-pull per debounce strap
`timescale 1ns/1ps
module strap_serial_drv (
  input  wire logic clk_sys,        // system clock
  input  wire logic rst_b,          // sync reset, active low
  input  wire logic open_drain,     // open-drain mode select
  input  wire logic data_bit,       // bit to send
  output logic      sdo_out,        // pad output level
  output logic      sdo_oe_b        // pad enable, low drives
);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sdo_out  <= 1'b1;
      sdo_oe_b <= 1'b1;
    end else if (open_drain) begin
      // release instead of driving high; board pull-up gives the one
      sdo_out  <= 1'b0;
      sdo_oe_b <= data_bit;
    end else begin
      sdo_out  <= data_bit;
      sdo_oe_b <= 1'b0;
    end
  end
endmodule

// ---- hdl/reset_strap_capture.sv ----
// strap capture during reset, decoded start-up config and readback port
`timescale 1ns/1ps
`include "strap_regs.svh"
module reset_strap_capture (
  input  wire logic                  clk_sys,           // 10 MHz system clock
  input  wire logic                  rst_b,             // sync reset, active low
  input  wire logic                  reset_input_n,     // board reset pin, active low
  input  wire logic [`STRAP_W-1:0]   strap_status_in,   // strap pin levels
  input  wire logic [`FAST_W-1:0]    fast_port_tx_in,   // fast tx enable pin levels
  input  wire logic [`UPL_W-1:0]     uplink_strap_in,   // {tx_error, tx_enable} levels
  input  wire strap_pkg::init_status_t init_status,     // status from init logic
  input  wire logic                  serial_bit,        // bit for serial data out
  input  wire logic                  host_frame_req,    // host asks frame transfer
  input  wire logic [`ADDR_W-1:0]    reg_addr,          // register address
  input  wire logic [`DATA_W-1:0]    reg_wdata,         // register write data
  input  wire logic                  reg_wr,            // write strobe
  input  wire logic                  reg_rd,            // read strobe
  output logic [`DATA_W-1:0]         reg_rdata,         // read data, cycle after strobe
  output logic [`STRAP_W-1:0]        strap_status_pins, // strap pins as outputs
  output logic                       strap_status_oe_b, // low drives status pins
  output logic                       serial_data_out,   // serial data pad level
  output logic                       serial_data_oe_b,  // low drives serial data pad
  output strap_pkg::strap_cfg_t      cfg_out,           // decoded start-up config
  output logic                       host_frame_grant,  // frame transfer permitted
  output logic                       eeprom_load_req    // start EEPROM load
);
  strap_pkg::cap_state_t state_reg;
  strap_pkg::cap_state_t state_next;
  logic [`STRAP_W-1:0] strap_sync_w;
  logic [`FAST_W-1:0]  fast_sync_w;
  logic [`UPL_W-1:0]   upl_sync_w;
  logic                rstin_sync_w;
  logic [`STRAP_W-1:0] strap_reg;
  logic [`FAST_W-1:0]  fast_reg;
  logic [`UPL_W-1:0]   upl_reg;
  logic                sdo_mode_reg;
  logic                test_bit_reg;
  strap_pkg::strap_cfg_t cfg_next;

  strap_sync #(.W(`STRAP_W + `FAST_W + `UPL_W + 1)) u_sync (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_in   ({strap_status_in, fast_port_tx_in, uplink_strap_in, reset_input_n}),
    .pin_sync ({strap_sync_w, fast_sync_w, upl_sync_w, rstin_sync_w})
  );

  // capture window: pin reset held; release then passes one settle state before run
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      strap_pkg::CAP_RESET:  if (rstin_sync_w) state_next = strap_pkg::CAP_SETTLE;
      strap_pkg::CAP_SETTLE: state_next = strap_pkg::CAP_RUN;
      strap_pkg::CAP_RUN:    if (!rstin_sync_w) state_next = strap_pkg::CAP_RESET;
      default:               state_next = strap_pkg::CAP_RESET;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) state_reg <= strap_pkg::CAP_RESET;
    else        state_reg <= state_next;
  end

  // levels are sampled every cycle of reset, frozen once released
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      strap_reg <= `STRAP_RST;
      fast_reg  <= '0;
      upl_reg   <= '0;
    end else if (state_reg == strap_pkg::CAP_RESET && !rstin_sync_w) begin
      strap_reg <= strap_sync_w;
      fast_reg  <= fast_sync_w;
      upl_reg   <= upl_sync_w;
    end
  end

  function automatic strap_pkg::strap_cfg_t decode_straps(input logic [`STRAP_W-1:0] s);
    strap_pkg::strap_cfg_t c;
    c.debounce_en      = s[`STRAP_DEBOUNCE];
    c.lightly_managed  = ~s[`STRAP_MGMT_MODE];
    c.dev_addr         = s[`STRAP_ADDR_HI:`STRAP_ADDR_LO];
    c.eeprom_present   = ~s[`STRAP_EEPROM_ABS];
    c.module_detect_en = s[`STRAP_MOD_DETECT];
    c.mac_power_save   = s[`STRAP_PWR_SAVE];
    c.timeout_reset_en = s[`STRAP_TO_RESET];
    return c;
  endfunction

  always_comb cfg_next = decode_straps(strap_reg);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_out          <= '0;
      host_frame_grant <= 1'b0;
      eeprom_load_req  <= 1'b0;
      sdo_mode_reg     <= 1'b0;
    end else begin
      cfg_out          <= cfg_next;
      sdo_mode_reg     <= cfg_next.debounce_en;
      host_frame_grant <= state_reg == strap_pkg::CAP_RUN && cfg_next.lightly_managed
                          && host_frame_req;
      eeprom_load_req  <= state_reg == strap_pkg::CAP_SETTLE && !cfg_next.lightly_managed
                          && cfg_next.eeprom_present;
    end
  end

  strap_serial_drv u_sdo (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .open_drain (sdo_mode_reg),
    .data_bit   (test_bit_reg),
    .sdo_out    (serial_data_out),
    .sdo_oe_b   (serial_data_oe_b)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) test_bit_reg <= 1'b1;
    else        test_bit_reg <= serial_bit;
  end

  // pins stay released while straps are sampled so board pulls win
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      strap_status_pins <= '0;
      strap_status_oe_b <= 1'b1;
    end else if (state_reg == strap_pkg::CAP_RUN) begin
      strap_status_pins <= {{(`STRAP_W-`STAT_W){1'b0}}, init_status};
      strap_status_oe_b <= 1'b0;
    end else begin
      strap_status_pins <= '0;
      strap_status_oe_b <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= `DATA_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFF_FAST_READBACK: reg_rdata <= {{(`DATA_W-`FAST_W){1'b0}}, fast_reg};
        `OFF_UPL_READBACK:  reg_rdata <= {{(`DATA_W-`UPL_W){1'b0}}, upl_reg};
        `OFF_STRAP_RAW:     reg_rdata <= {{(`DATA_W-`STRAP_W){1'b0}}, strap_reg};
        `OFF_CONFIG:        reg_rdata <= {{(`DATA_W-$bits(cfg_out)){1'b0}}, cfg_out};
        default:            reg_rdata <= `DATA_ZERO;
      endcase
    end else begin
      reg_rdata <= `DATA_ZERO;
    end
  end

  // straps are read-only; writes have no effect
  logic unused_w;
  always_comb unused_w = reg_wr ^ (|reg_wdata);

  // capture walks reset, one settle cycle, then run
  sequence capture_cycle_s;
    state_reg == strap_pkg::CAP_RESET && !rstin_sync_w;
  endsequence
  sequence pin_release_s;
    state_reg == strap_pkg::CAP_RESET && rstin_sync_w;
  endsequence
  sequence settle_then_run_s;
    state_reg == strap_pkg::CAP_SETTLE ##1 state_reg == strap_pkg::CAP_RUN;
  endsequence
  sequence frozen_cycle_s;
    state_reg == strap_pkg::CAP_RUN && $past(state_reg) == strap_pkg::CAP_RUN;
  endsequence

  frozen_after_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    frozen_cycle_s |-> $stable(strap_reg))
    else $error("strap latch changed after reset");
  fast_frozen_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    frozen_cycle_s |-> $stable(fast_reg) && $stable(upl_reg))
    else $error("port strap latch changed after reset");
  capture_live_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    capture_cycle_s |=> strap_reg == $past(strap_sync_w))
    else $error("strap not captured during reset");
  fast_capture_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    capture_cycle_s |=> fast_reg == $past(fast_sync_w))
    else $error("fast port strap not captured during reset");
  upl_capture_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    capture_cycle_s |=> upl_reg == $past(upl_sync_w))
    else $error("uplink strap not captured during reset");
  release_walk_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    pin_release_s |=> settle_then_run_s)
    else $error("release did not settle into run");
  state_onehot_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b) $onehot(state_reg))
    else $error("capture state not one-hot");

  // decode lags the latch by one flop; the cycle after reset still shows reset values
  addr_field_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> cfg_out.dev_addr == $past(strap_reg[`STRAP_ADDR_HI:`STRAP_ADDR_LO]))
    else $error("device address not taken from straps");
  addr_order_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> cfg_out.dev_addr[0] == $past(strap_reg[`STRAP_ADDR_LO]))
    else $error("device address order wrong");
  debounce_map_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> cfg_out.debounce_en == $past(strap_reg[`STRAP_DEBOUNCE]))
    else $error("debounce strap decode wrong");
  mgmt_map_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> cfg_out.lightly_managed == !$past(strap_reg[`STRAP_MGMT_MODE]))
    else $error("management strap polarity wrong");
  eeprom_abs_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> cfg_out.eeprom_present == !$past(strap_reg[`STRAP_EEPROM_ABS]))
    else $error("eeprom presence polarity wrong");
  detect_map_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> cfg_out.module_detect_en == $past(strap_reg[`STRAP_MOD_DETECT]))
    else $error("module detect strap decode wrong");
  power_mode_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> cfg_out.mac_power_save == $past(strap_reg[`STRAP_PWR_SAVE]) &&
    cfg_out.module_detect_en == $past(strap_reg[`STRAP_MOD_DETECT]) &&
    cfg_out.debounce_en == $past(strap_reg[`STRAP_DEBOUNCE]))
    else $error("mode strap decode wrong");
  sdo_mode_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> sdo_mode_reg == $past(strap_reg[`STRAP_DEBOUNCE]))
    else $error("serial port mode does not follow debounce strap");

  // pad checks see the driver one flop behind its mode and data
  debounce_od_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sdo_mode_reg |=> !(serial_data_out && !serial_data_oe_b))
    else $error("open drain drove high");
  od_follow_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sdo_mode_reg |=> !serial_data_out && serial_data_oe_b == $past(test_bit_reg))
    else $error("open drain enable does not follow data");
  pushpull_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) && !sdo_mode_reg
    |=> !serial_data_oe_b && serial_data_out == $past(test_bit_reg))
    else $error("push-pull data out not driven");

  grant_block_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    strap_reg[`STRAP_MGMT_MODE] |=> !host_frame_grant)
    else $error("frame granted in unmanaged mode");
  grant_allow_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    state_reg == strap_pkg::CAP_RUN && !strap_reg[`STRAP_MGMT_MODE] && host_frame_req
    |=> host_frame_grant)
    else $error("frame refused in lightly managed mode");
  grant_run_only_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    state_reg != strap_pkg::CAP_RUN |=> !host_frame_grant)
    else $error("frame granted during capture");
  load_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    state_reg == strap_pkg::CAP_SETTLE && strap_reg[`STRAP_MGMT_MODE]
    && !strap_reg[`STRAP_EEPROM_ABS] |=> eeprom_load_req)
    else $error("eeprom load not requested");
  load_single_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    eeprom_load_req |=> !eeprom_load_req)
    else $error("eeprom load request longer than one cycle");
  load_absent_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    strap_reg[`STRAP_EEPROM_ABS] |=> !eeprom_load_req)
    else $error("eeprom load requested with eeprom absent");
  load_managed_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !strap_reg[`STRAP_MGMT_MODE] |=> !eeprom_load_req)
    else $error("eeprom load requested in lightly managed mode");

  status_release_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    state_reg != strap_pkg::CAP_RUN |=> strap_status_oe_b)
    else $error("status pins driven during capture");
  status_drive_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    state_reg == strap_pkg::CAP_RUN |=> !strap_status_oe_b
    && strap_status_pins == {{(`STRAP_W-`STAT_W){1'b0}}, $past(init_status)})
    else $error("status pins not reporting init status");
  status_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    state_reg != strap_pkg::CAP_RUN |=> strap_status_pins == '0)
    else $error("status levels present during capture");

  fast_read_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == `OFF_FAST_READBACK |=> reg_rdata[`FAST_W-1:0] == $past(fast_reg))
    else $error("fast readback wrong");
  upl_read_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == `OFF_UPL_READBACK
    |=> reg_rdata == {{(`DATA_W-`UPL_W){1'b0}}, $past(upl_reg)})
    else $error("uplink readback wrong");
  raw_read_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == `OFF_STRAP_RAW |=> reg_rdata[`STRAP_W-1:0] == $past(strap_reg))
    else $error("raw strap readback wrong");
  rdata_idle_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == `DATA_ZERO)
    else $error("read data present without a read");
endmodule

// ---- dv/board_pulls.sv ----
// board pull resistors on the strap and transmit enable pins
`timescale 1ns/1ps
module board_pulls (
  input  wire logic [15:0] pull_strap,  // resistor level per strap pin
  input  wire logic [7:0]  pull_fast,   // resistor level per fast tx pin
  input  wire logic [1:0]  pull_upl,    // resistor level, {error, enable}
  input  wire logic [15:0] status_pins, // device drive on strap pins
  input  wire logic        status_oe_b, // low while device drives
  output logic      [15:0] strap_lvl,   // wire level of strap pins
  output logic      [7:0]  fast_lvl,    // wire level of fast tx pins
  output logic      [1:0]  upl_lvl      // wire level of uplink pins
);
  // a released pin settles to its pull, a driven one follows the device
  assign strap_lvl = status_oe_b ? pull_strap : status_pins;
  assign fast_lvl  = pull_fast;
  assign upl_lvl   = pull_upl;
endmodule

// ---- dv/reset_strap_capture_bench.sv ----
// self-checking bench for the reset strap capture block
`timescale 1ns/1ps
`include "strap_regs.svh"
module reset_strap_capture_bench;
  logic                    clk_sys = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    reset_input_n = 1'b0;
  logic [15:0]             pull_strap = 16'hFFFF;
  logic [7:0]              pull_fast = 8'h00;
  logic [1:0]              pull_upl = 2'b11;
  logic [15:0]             strap_lvl;
  logic [7:0]              fast_lvl;
  logic [1:0]              upl_lvl;
  strap_pkg::init_status_t init_status = 4'hA;
  logic                    serial_bit = 1'b0;
  logic                    host_frame_req = 1'b0;
  logic [3:0]              reg_addr = 4'h0;
  logic [31:0]             reg_wdata = 32'h0;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic [31:0]             reg_rdata;
  logic [15:0]             strap_status_pins;
  logic                    status_oe_b, sdo, sdo_oe_b, grant, load_req;
  strap_pkg::strap_cfg_t   cfg_out;
  int                      num_errors = 0;
  int                      n_checks = 0;
  int                      cyc = 0;

  board_pulls pulls (.pull_strap(pull_strap), .pull_fast(pull_fast), .pull_upl(pull_upl),
    .status_pins(strap_status_pins), .status_oe_b(status_oe_b), .strap_lvl(strap_lvl),
    .fast_lvl(fast_lvl), .upl_lvl(upl_lvl));
  reset_strap_capture dut (.clk_sys(clk_sys), .rst_b(rst_b), .reset_input_n(reset_input_n),
    .strap_status_in(strap_lvl), .fast_port_tx_in(fast_lvl), .uplink_strap_in(upl_lvl),
    .init_status(init_status), .serial_bit(serial_bit), .host_frame_req(host_frame_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .strap_status_pins(strap_status_pins),
    .strap_status_oe_b(status_oe_b), .serial_data_out(sdo), .serial_data_oe_b(sdo_oe_b),
    .cfg_out(cfg_out), .host_frame_grant(grant), .eeprom_load_req(load_req));

  always #50 clk_sys = ~clk_sys;

  task automatic finish_test;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // a run of two cases takes under a hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      num_errors++;
      finish_test;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic run_case(input logic [15:0] s, input logic [7:0] f, input logic [1:0] u);
    strap_pkg::strap_cfg_t e;
    logic [31:0]           d;
    int                    pulses;
    e = {s[0], ~s[3], s[6:4], ~s[7], s[9], s[11], s[12]};
    pulses = 0;
    @(posedge clk_sys);
    reset_input_n <= 1'b0;
    pull_strap    <= s;
    pull_fast     <= f;
    pull_upl      <= u;
    repeat (10) @(posedge clk_sys);
    chk("status enable in capture", 32'h1, {31'h0, status_oe_b});
    reset_input_n <= 1'b1;
    repeat (10) begin
      @(posedge clk_sys);
      #1 if (load_req === 1'b1) pulses++;
    end
    chk("load pulses", {31'h0, s[3] & ~s[7]}, pulses);
    chk("config", {23'h0, e}, {23'h0, cfg_out});
    chk("status pins", {20'h0, init_status}, {16'h0, strap_status_pins});
    chk("status enable in run", 32'h0, {31'h0, status_oe_b});
    // disturb the pins after release; the captured values must not move
    pull_fast  <= ~f;
    pull_upl   <= ~u;
    pull_strap <= ~s;
    wr(`OFF_STRAP_RAW, 32'hFFFF_FFFF);
    rd(`OFF_FAST_READBACK, d);
    chk("fast readback", {24'h0, f}, d);
    rd(`OFF_UPL_READBACK, d);
    chk("uplink readback", {30'h0, u}, d);
    rd(`OFF_STRAP_RAW, d);
    chk("raw straps", {16'h0, s}, d);
    rd(`OFF_CONFIG, d);
    chk("config readback", {23'h0, e}, d);
    rd(4'h9, d);
    chk("unmapped read", 32'h0, d);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_sys);
      serial_bit     <= b[0];
      host_frame_req <= b[0];
      repeat (3) @(posedge clk_sys);
      #1;
      chk("serial out", {31'h0, ~s[0] & b[0]}, {31'h0, sdo});
      chk("serial enable", {31'h0, s[0] & b[0]}, {31'h0, sdo_oe_b});
      chk("frame grant", {31'h0, ~s[3] & b[0]}, {31'h0, grant});
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    // debounce on, lightly managed, address 5, EEPROM absent, detect on
    run_case(16'hF3D7, 8'hA5, 2'b01);
    @(posedge clk_sys);
    init_status <= 4'h5;
    // debounce off, unmanaged, address 2, EEPROM present, power save on
    run_case(16'hE92E, 8'h5A, 2'b10);
    finish_test;
  end
endmodule
